// file: core/rpsr_port_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Read-only field shows connected input port number
// - Connection field resets to 31, shows 31 unconnected
// - Type field: 000 config, 001 link, 010 external
// - Failed command sets flag and gets NACK
// - Error flags held until error-active register cleared
// - Unknown address or read-only write flags error
// - Protocol identifier other than 01h flags error
// - Invalid source logical address flags error
// - Oversized command packet flags error
// - Unassigned command code or packet type flags
// - Bit 17 and bits 23:20 unused, zero
// - Error-active bit is OR of link errors
// - Wrong destination address sets link flag
// - Output blocked for timeout sets flag
// - One flag each for five link errors
// - State field mirrors link state machine
// - Running bit set exactly in Run state
// - Writable autostart bit, resets to one
// - Autostart waits for far end, then starts
// - Port register address equals port number
module rpsr_port_regs #(
    parameter int NUM_LINKS = 8,
    parameter int ADDR_W = 8,
    parameter int TIMEOUT_CYC = 1024
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [31:0] cmdWdata,
    input wire logic [7:0] cmdProtoId,
    input wire logic cmdSrcAddrBad,
    input wire logic cmdTooLarge,
    input wire logic cmdCodeBad,
    output logic rspValid,
    output logic [31:0] rspData,
    output logic rspNack,
    input wire logic [NUM_LINKS:0] errClear,
    input wire logic [NUM_LINKS:0] connValid,
    input wire logic [5*(NUM_LINKS+1)-1:0] connSrc,
    input wire logic [NUM_LINKS-1:0] lnkAddrErr,
    input wire logic [NUM_LINKS-1:0] lnkOutBlocked,
    input wire logic [NUM_LINKS-1:0] lnkDiscErr,
    input wire logic [NUM_LINKS-1:0] lnkParErr,
    input wire logic [NUM_LINKS-1:0] lnkEscErr,
    input wire logic [NUM_LINKS-1:0] lnkCredErr,
    input wire logic [NUM_LINKS-1:0] lnkSeqErr,
    input wire logic [NUM_LINKS-1:0] lnkGotNull,
    input wire logic [NUM_LINKS-1:0] lnkGotFct,
    output logic [3*NUM_LINKS-1:0] lnkState,
    output logic [NUM_LINKS-1:0] lnkRunning,
    output logic [NUM_LINKS-1:0] lnkAutoStart
);

    localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic addrKnown(input logic [ADDR_W-1:0] a);
        addrKnown = (a <= ADDR_W'(NUM_LINKS));
    endfunction

    // Link register select, shared by write and read paths
    function automatic logic isLink(input logic [ADDR_W-1:0] idx, input int n);
        isLink = (idx == ADDR_W'(n));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Current connection of every port

    logic [4:0] conn_q [0:NUM_LINKS];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p <= NUM_LINKS; p++) begin
                conn_q[p] <= rpsr_pkg::CONN_NONE;
            end
        end else begin
            for (int p = 0; p <= NUM_LINKS; p++) begin
                if (connValid[p]) begin
                    conn_q[p] <= connSrc[5*p +: 5];
                end else begin
                    conn_q[p] <= rpsr_pkg::CONN_NONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration command checks

    logic [rpsr_pkg::CFG_ERR_W-1:0] cfgSet;
    logic [rpsr_pkg::CFG_ERR_W-1:0] cfgFlags;
    logic cmdFail;

    always_comb begin
        cfgSet = '0;
        if (cmdValid) begin
            cfgSet[rpsr_pkg::CFG_ADDR_BIT] = !addrKnown(cmdAddr)
                || (cmdWrite && cmdAddr == ADDR_W'(rpsr_pkg::CFG_PORT_ADDR));
            cfgSet[rpsr_pkg::CFG_PROTO_BIT] = (cmdProtoId != rpsr_pkg::RMAP_PROTO_ID);
            cfgSet[rpsr_pkg::CFG_SRC_BIT] = cmdSrcAddrBad;
            cfgSet[rpsr_pkg::CFG_LARGE_BIT] = cmdTooLarge;
            cfgSet[rpsr_pkg::CFG_CODE_BIT] = cmdCodeBad;
        end
        cfgSet[rpsr_pkg::CFG_UNUSED_BIT] = 1'b0;
    end

    assign cmdFail = |cfgSet;

    rpsr_sticky #(
        .W(rpsr_pkg::CFG_ERR_W)
    ) u_cfg_flags (
        .core_clk(core_clk),
        .resetn(resetn),
        .setBits(cfgSet),
        .clear(errClear[0]),
        .flags(cfgFlags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link ports

    logic [rpsr_pkg::LNK_ERR_W-1:0] lnkFlags [0:NUM_LINKS-1];
    logic [NUM_LINKS-1:0] autoStart_q;
    logic [ADDR_W-1:0] linkIdx;

    assign linkIdx = cmdAddr - ADDR_W'(1);

    // Only the autostart bit is writable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            autoStart_q <= {NUM_LINKS{rpsr_pkg::LNK_AUTO_RST}};
        end else if (cmdValid && cmdWrite && !cmdFail) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                if (isLink(linkIdx, i)) begin
                    autoStart_q[i] <= cmdWdata[rpsr_pkg::LNK_AUTO_BIT];
                end
            end
        end
    end

    assign lnkAutoStart = autoStart_q;

    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link
        logic [TMO_W-1:0] tmo_q;
        logic tmoHit;
        logic [rpsr_pkg::LNK_ERR_W-1:0] setBits;

        // Counter saturates so a long blockage reports once
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                tmo_q <= '0;
            end else if (!lnkOutBlocked[g]) begin
                tmo_q <= '0;
            end else if (tmo_q != TMO_W'(TIMEOUT_CYC)) begin
                tmo_q <= tmo_q + TMO_W'(1);
            end
        end

        assign tmoHit = lnkOutBlocked[g] && tmo_q == TMO_W'(TIMEOUT_CYC - 1);

        assign setBits = {lnkSeqErr[g], lnkCredErr[g], lnkEscErr[g], lnkParErr[g],
            lnkDiscErr[g], tmoHit, lnkAddrErr[g]};

        rpsr_sticky #(
            .W(rpsr_pkg::LNK_ERR_W)
        ) u_lnk_flags (
            .core_clk(core_clk),
            .resetn(resetn),
            .setBits(setBits),
            .clear(errClear[g+1]),
            .flags(lnkFlags[g])
        );

        rpsr_link_fsm u_fsm (
            .core_clk(core_clk),
            .resetn(resetn),
            .autoStart(autoStart_q[g]),
            .linkErr(lnkDiscErr[g] | lnkParErr[g] | lnkEscErr[g]
                | lnkCredErr[g] | lnkSeqErr[g]),
            .gotNull(lnkGotNull[g]),
            .gotFct(lnkGotFct[g]),
            .state(lnkState[3*g +: 3]),
            .running(lnkRunning[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read word assembly

    logic [31:0] rdWord;

    always_comb begin
        rdWord = '0;
        if (cmdAddr == ADDR_W'(rpsr_pkg::CFG_PORT_ADDR)) begin
            rdWord[rpsr_pkg::TYPE_LSB +: 3] = rpsr_pkg::PORT_TYPE_CFG;
            rdWord[rpsr_pkg::CONN_LSB +: rpsr_pkg::CONN_W] = conn_q[0];
            rdWord[rpsr_pkg::CFG_ERR_LSB +: rpsr_pkg::CFG_ERR_W] = cfgFlags;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                if (isLink(linkIdx, i)) begin
                    rdWord[rpsr_pkg::TYPE_LSB +: 3] = rpsr_pkg::PORT_TYPE_LINK;
                    rdWord[rpsr_pkg::CONN_LSB +: rpsr_pkg::CONN_W] = conn_q[i+1];
                    rdWord[rpsr_pkg::LNK_ACT_BIT] = |lnkFlags[i];
                    rdWord[rpsr_pkg::LNK_ERR_LSB +: rpsr_pkg::LNK_ERR_W] = lnkFlags[i];
                    rdWord[rpsr_pkg::LNK_STATE_LSB +: 3] = lnkState[3*i +: 3];
                    rdWord[rpsr_pkg::LNK_RUN_BIT] = lnkRunning[i];
                    rdWord[rpsr_pkg::LNK_AUTO_BIT] = autoStart_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rspValid <= 1'b0;
            rspNack <= 1'b0;
            rspData <= '0;
        end else begin
            rspValid <= cmdValid;
            rspNack <= cmdValid && cmdFail;
            if (cmdValid) begin
                rspData <= cmdFail ? 32'h00000000 : rdWord;
            end
        end
    end

endmodule // rpsr_port_regs

`default_nettype wire

// file: core/rpsr_pkg.sv
package rpsr_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Port kinds shown in the type field
    localparam logic [2:0] PORT_TYPE_CFG = 3'h0;
    localparam logic [2:0] PORT_TYPE_LINK = 3'h1;
    localparam logic [2:0] PORT_TYPE_EXT = 3'h2;

    // Generic fields
    localparam int TYPE_LSB = 29;
    localparam int CONN_LSB = 24;
    localparam int CONN_W = 5;
    localparam logic [4:0] CONN_NONE = 5'h1F;

    // Configuration port fields
    localparam int CFG_ERR_LSB = 14;
    localparam int CFG_ERR_W = 6;
    localparam int CFG_ADDR_BIT = 0;
    localparam int CFG_PROTO_BIT = 1;
    localparam int CFG_SRC_BIT = 2;
    localparam int CFG_UNUSED_BIT = 3;
    localparam int CFG_LARGE_BIT = 4;
    localparam int CFG_CODE_BIT = 5;
    localparam logic [7:0] RMAP_PROTO_ID = 8'h01;
    localparam int CFG_PORT_ADDR = 0;

    // Link port fields
    localparam int LNK_ACT_BIT = 0;
    localparam int LNK_ERR_LSB = 1;
    localparam int LNK_ERR_W = 7;
    localparam int LNK_STATE_LSB = 8;
    localparam int LNK_RUN_BIT = 11;
    localparam int LNK_AUTO_BIT = 12;
    localparam logic LNK_AUTO_RST = 1'b1;

    // Link start-up timing
    localparam int T_ERR_RESET_NS = 6400;
    localparam int T_ERR_WAIT_NS = 12800;
    localparam int T_CONNECT_NS = 12800;
    localparam int ERR_RESET_CYC = T_ERR_RESET_NS / CLK_PERIOD_NS;
    localparam int ERR_WAIT_CYC = T_ERR_WAIT_NS / CLK_PERIOD_NS;
    localparam int CONNECT_CYC = T_CONNECT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        LS_ERROR_RESET = 3'h0,
        LS_ERROR_WAIT = 3'h1,
        LS_READY = 3'h2,
        LS_STARTED = 3'h3,
        LS_CONNECTING = 3'h4,
        LS_RUN = 3'h5
    } rpsr_link_state_type;

endpackage

// file: core/rpsr_sticky.sv
`timescale 1ns/100ps
`default_nettype none

module rpsr_sticky #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] setBits,
    input wire logic clear,
    output logic [W-1:0] flags
);

    logic [W-1:0] flags_q;

    // A set in the clear cycle survives
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~{W{clear}}) | setBits;
        end
    end

    assign flags = flags_q;

endmodule // rpsr_sticky

`default_nettype wire

// file: core/rpsr_link_fsm.sv
`timescale 1ns/100ps
`default_nettype none

module rpsr_link_fsm (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic autoStart,
    input wire logic linkErr,
    input wire logic gotNull,
    input wire logic gotFct,
    output logic [2:0] state,
    output logic running
);

    localparam int CNT_W = 12;

    rpsr_pkg::rpsr_link_state_type state_q;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= rpsr_pkg::LS_ERROR_RESET;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 12'h001;
            case (state_q)
                rpsr_pkg::LS_ERROR_RESET: begin
                    if (cnt_q == CNT_W'(rpsr_pkg::ERR_RESET_CYC - 1)) begin
                        state_q <= rpsr_pkg::LS_ERROR_WAIT;
                        cnt_q <= '0;
                    end
                end
                rpsr_pkg::LS_ERROR_WAIT: begin
                    if (linkErr) begin
                        state_q <= rpsr_pkg::LS_ERROR_RESET;
                        cnt_q <= '0;
                    end else if (cnt_q == CNT_W'(rpsr_pkg::ERR_WAIT_CYC - 1)) begin
                        state_q <= rpsr_pkg::LS_READY;
                        cnt_q <= '0;
                    end
                end
                rpsr_pkg::LS_READY: begin
                    cnt_q <= '0;
                    if (linkErr) begin
                        state_q <= rpsr_pkg::LS_ERROR_RESET;
                    end else if (autoStart && gotNull) begin
                        state_q <= rpsr_pkg::LS_STARTED;
                    end
                end
                rpsr_pkg::LS_STARTED, rpsr_pkg::LS_CONNECTING: begin
                    if (linkErr || cnt_q == CNT_W'(rpsr_pkg::CONNECT_CYC - 1)) begin
                        state_q <= rpsr_pkg::LS_ERROR_RESET;
                        cnt_q <= '0;
                    end else if (state_q == rpsr_pkg::LS_STARTED && gotNull) begin
                        state_q <= rpsr_pkg::LS_CONNECTING;
                    end else if (state_q == rpsr_pkg::LS_CONNECTING && gotFct) begin
                        state_q <= rpsr_pkg::LS_RUN;
                    end
                end
                rpsr_pkg::LS_RUN: begin
                    cnt_q <= '0;
                    if (linkErr) begin
                        state_q <= rpsr_pkg::LS_ERROR_RESET;
                    end
                end
                default: begin
                    state_q <= rpsr_pkg::LS_ERROR_RESET;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    assign state = state_q;
    assign running = (state_q == rpsr_pkg::LS_RUN);

endmodule // rpsr_link_fsm

`default_nettype wire

// file: sim/rpsr_port_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module rpsr_port_regs_assertions #(
    parameter int NUM_LINKS = 8,
    parameter int ADDR_W = 8,
    parameter int TIMEOUT_CYC = 1024
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [31:0] cmdWdata,
    input wire logic [7:0] cmdProtoId,
    input wire logic cmdSrcAddrBad,
    input wire logic cmdTooLarge,
    input wire logic cmdCodeBad,
    input wire logic rspValid,
    input wire logic [31:0] rspData,
    input wire logic rspNack,
    input wire logic [NUM_LINKS-1:0] lnkDiscErr,
    input wire logic [3*NUM_LINKS-1:0] lnkState,
    input wire logic [NUM_LINKS-1:0] lnkRunning,
    input wire logic [NUM_LINKS-1:0] lnkAutoStart
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Command with no packet-level fault
    logic cmdClean;
    assign cmdClean = cmdValid && cmdProtoId == 8'h01 && !cmdSrcAddrBad && !cmdTooLarge
        && !cmdCodeBad;

    a_rsp_next: assert property (cmdValid |=> rspValid)
        else $error("reply missing after command");
    a_nack_zero: assert property (rspNack |-> rspValid && rspData == 32'h0)
        else $error("refusal without reply or with data");
    a_bad_addr: assert property (cmdValid && (int'(cmdAddr) > NUM_LINKS
        || (cmdWrite && cmdAddr == '0)) |=> rspNack)
        else $error("bad address not refused");
    a_pkt_refused: assert property (cmdValid && !cmdClean |=> rspNack)
        else $error("faulty packet not refused");
    a_cfg_word: assert property (cmdClean && !cmdWrite && cmdAddr == '0
        |=> !rspNack && rspData[31:29] == 3'h0 && rspData[23:20] == 4'h0 && !rspData[17])
        else $error("configuration word malformed");
    a_link_type: assert property (cmdClean && !cmdWrite && cmdAddr == 1
        |=> !rspNack && rspData[31:29] == 3'h1)
        else $error("link word type wrong");
    a_auto_write: assert property (cmdClean && cmdWrite && cmdAddr == 1
        |=> lnkAutoStart[0] == $past(cmdWdata[12]))
        else $error("autostart not written");
    a_auto_hold: assert property (!(cmdValid && cmdWrite) |=> $stable(lnkAutoStart))
        else $error("autostart changed without write");
    a_run_bit: assert property (lnkRunning[0] == (lnkState[2:0] == 3'h5))
        else $error("running bit disagrees with state");
    a_state_legal: assert property (lnkState[2:0] <= 3'h5)
        else $error("illegal link state");
    a_run_entry: assert property ($rose(lnkRunning[0]) |-> $past(lnkState[2:0]) == 3'h4)
        else $error("run entered not from connecting");
    a_err_leaves: assert property (lnkState[2:0] == 3'h5 && lnkDiscErr[0]
        |=> lnkState[2:0] == 3'h0)
        else $error("error in run did not reset link");
endmodule // rpsr_port_regs_assertions

bind rpsr_port_regs rpsr_port_regs_assertions #(.NUM_LINKS(NUM_LINKS), .ADDR_W(ADDR_W),
    .TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.core_clk, .resetn, .cmdValid, .cmdWrite, .cmdAddr,
    .cmdWdata, .cmdProtoId, .cmdSrcAddrBad, .cmdTooLarge, .cmdCodeBad, .rspValid, .rspData,
    .rspNack, .lnkDiscErr, .lnkState, .lnkRunning, .lnkAutoStart);

`default_nettype wire

// file: sim/rpsr_far_end.sv
`timescale 1ns/100ps
`default_nettype none

module rpsr_far_end #(
    parameter int FCT_DLY = 3
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [2:0] state,
    output logic gotNull,
    output logic gotFct
);
    logic [3:0] wait_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gotNull <= 1'b0;
            gotFct <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            gotNull <= enable; // Far end keeps trying to connect
            gotFct <= enable && state == 3'h4 && wait_q == 4'(FCT_DLY);
            wait_q <= (state == 3'h4) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // rpsr_far_end

`default_nettype wire

// file: sim/router_port_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module router_port_status_regs_test;
    localparam int NL = 2;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdWrite = 1'b0;
    logic [7:0] cmdAddr = 8'h00;
    logic [31:0] cmdWdata = 32'h0;
    logic [7:0] cmdProtoId = 8'h01;
    logic cmdSrcAddrBad = 1'b0;
    logic cmdTooLarge = 1'b0;
    logic cmdCodeBad = 1'b0;
    logic [NL:0] errClear = '0;
    logic [NL:0] connValid = '0;
    logic [14:0] connSrc = '0;
    logic [6:0][NL-1:0] lerr = '0;
    logic pEn = 1'b0;
    logic rspValid, rspNack, pNull, pFct, nk;
    logic [31:0] rspData, rd;
    logic [3*NL-1:0] lnkState;
    logic [NL-1:0] lnkRunning, lnkAutoStart;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;

    rpsr_port_regs #(.NUM_LINKS(NL), .ADDR_W(8), .TIMEOUT_CYC(8)) i_dut (
        .core_clk, .resetn, .cmdValid, .cmdWrite, .cmdAddr, .cmdWdata, .cmdProtoId,
        .cmdSrcAddrBad, .cmdTooLarge, .cmdCodeBad, .rspValid, .rspData, .rspNack,
        .errClear, .connValid, .connSrc, .lnkAddrErr(lerr[0]), .lnkOutBlocked(lerr[1]),
        .lnkDiscErr(lerr[2]), .lnkParErr(lerr[3]), .lnkEscErr(lerr[4]),
        .lnkCredErr(lerr[5]), .lnkSeqErr(lerr[6]), .lnkGotNull({1'b0, pNull}),
        .lnkGotFct({1'b0, pFct}), .lnkState, .lnkRunning, .lnkAutoStart);

    rpsr_far_end i_far (.core_clk, .resetn, .enable(pEn), .state(lnkState[2:0]),
        .gotNull(pNull), .gotFct(pFct));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One command, reply taken the cycle after
    task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] wd,
        input logic [7:0] p, input logic [2:0] b);
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdWrite = w;
        cmdAddr = a;
        cmdWdata = wd;
        cmdProtoId = p;
        {cmdSrcAddrBad, cmdTooLarge, cmdCodeBad} = b;
        @(negedge core_clk);
        cmdValid = 1'b0;
        cmp({31'h0, rspValid}, 32'h1);
        rd = rspData;
        nk = rspNack;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        cmd(1'b0, a, 32'h0, 8'h01, 3'h0);
        cmp({31'h0, nk}, 32'h0);
        cmp(rd & m, e);
    endtask

    task automatic wait_state(input logic [2:0] s, input int lim);
        for (int i = 0; i < lim && lnkState[2:0] !== s; i++) @(negedge core_clk);
        cmp({29'h0, lnkState[2:0]}, {29'h0, s});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        rdc(8'h00, 32'hFFFFFFFF, 32'h1F000000);
        rdc(8'h01, 32'hFFFFFFFF, 32'h3F001000);
        connValid = 3'b101;
        connSrc = {5'h04, 5'h00, 5'h05};
        repeat (2) @(negedge core_clk);
        rdc(8'h00, 32'hFFFFFFFF, 32'h05000000);
        rdc(8'h02, 32'hFFFFF8FF, 32'h24001000);
        connValid = 3'b000;
        repeat (2) @(negedge core_clk);
        rdc(8'h02, 32'hFFFFF8FF, 32'h3F001000);
        for (int i = 0; i < 6; i++) begin
            int b;
            b = (i < 2) ? 14 : ((i < 4) ? i + 13 : i + 14);
            case (i)
                0: cmd(1'b1, 8'h00, 32'h0, 8'h01, 3'h0);
                1: cmd(1'b0, 8'h03, 32'h0, 8'h01, 3'h0);
                2: cmd(1'b0, 8'h01, 32'h0, 8'h5A, 3'h0);
                3: cmd(1'b0, 8'h01, 32'h0, 8'h01, 3'h4);
                4: cmd(1'b0, 8'h01, 32'h0, 8'h01, 3'h2);
                default: cmd(1'b0, 8'h01, 32'h0, 8'h01, 3'h1);
            endcase
            cmp({31'h0, nk}, 32'h1);
            cmp(rd, 32'h0);
            rdc(8'h00, 32'hFFFFFFFF, 32'h1F000000 | (32'h1 << b));
            errClear[0] = 1'b1;
            @(negedge core_clk);
            errClear[0] = 1'b0;
            rdc(8'h00, 32'hFFFFFFFF, 32'h1F000000);
        end
        for (int p = 0; p < NL; p++) begin
            for (int k = 0; k < 7; k++) begin
                lerr[k][p] = 1'b1;
                repeat ((k == 1) ? 9 : 1) @(negedge core_clk);
                lerr[k][p] = 1'b0;
                rdc(8'(p + 1), 32'hFFFFF8FF, 32'h3F001001 | (32'h2 << k));
                errClear[p + 1] = 1'b1;
                @(negedge core_clk);
                errClear[p + 1] = 1'b0;
                rdc(8'(p + 1), 32'hFFFFF8FF, 32'h3F001000);
            end
        end
        // Error and clear in one cycle: the error must win
        lerr[0][0] = 1'b1;
        errClear[1] = 1'b1;
        @(negedge core_clk);
        lerr[0][0] = 1'b0;
        errClear[1] = 1'b0;
        rdc(8'h01, 32'hFFFFF8FF, 32'h3F001003);
        errClear[1] = 1'b1;
        @(negedge core_clk);
        errClear[1] = 1'b0;
        cmd(1'b1, 8'h01, 32'hFFFFEFFF, 8'h01, 3'h0);
        cmp({31'h0, nk}, 32'h0);
        rdc(8'h01, 32'hFFFFF8FF, 32'h3F000000);
        cmp({30'h0, lnkAutoStart}, 32'h2);
        wait_state(3'h2, 2500);
        pEn = 1'b1;
        repeat (40) @(negedge core_clk);
        cmp({29'h0, lnkState[2:0]}, 32'h2);
        cmd(1'b1, 8'h01, 32'h00001000, 8'h01, 3'h0);
        wait_state(3'h5, 100);
        rdc(8'h01, 32'hFFFFFFFF, 32'h3F001D00);
        cmp({30'h0, lnkRunning}, 32'h1);
        lerr[2][0] = 1'b1;
        @(negedge core_clk);
        lerr[2][0] = 1'b0;
        rdc(8'h01, 32'hFFFFFFFF, 32'h3F001009);
        give_verdict();
    end
endmodule // router_port_status_regs_test

`default_nettype wire
